/* File: dv/pspc_board.sv */
// Board model: port power switches, strap resistor and pulled-up EEPROM clock line.
`timescale 1ns/1ps
module pspc_board (
	input wire logic strap,
	input wire logic [1:0] oc_fault,
	input wire logic [1:0] pp_o,
	input wire logic [1:0] pp_oe,
	input wire logic [1:0] pp_pu,
	input wire logic sd_o,
	input wire logic sd_oe,
	input wire logic ck_o,
	input wire logic ck_oe,
	output logic [1:0] pp_pin,
	output logic sd_pin,
	output logic ck_pin
);
	// A faulted switch pulls its flag low, which beats the weak pull-up.
	assign pp_pin = (pp_oe & pp_o) | (~pp_oe & pp_pu & ~oc_fault);
	// The strap resistor is stronger than the internal pull-down, so it sets a released pin.
	assign sd_pin = sd_oe ? sd_o : strap;
	// The EEPROM clock line has a board pull-up.
	assign ck_pin = ck_oe ? ck_o : 1'b1;
endmodule

/* File: dv/pspc_pin_ctl_checker.sv */
// Checker of strap, ROM pin, port power and connect relations.
`timescale 1ns/1ps
module pspc_pin_ctl_checker #(
	parameter int NPORTS = 2,
	parameter int OC_FILTER = 16
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic wb_ack_o,
	input wire logic suspend,
	input wire logic rom_strap_data_oe,
	input wire logic rom_strap_pulldown_en,
	input wire logic rom_clock_o,
	input wire logic rom_clock_oe,
	input wire logic rom_chip_sel_n,
	input wire logic [NPORTS-1:0] port_power_enable_i,
	input wire logic [NPORTS-1:0] port_power_enable_o,
	input wire logic [NPORTS-1:0] port_power_enable_oe,
	input wire logic [NPORTS-1:0] port_power_pullup_en,
	input wire logic upstream_power_sense,
	input wire logic upstream_pullup_en,
	input wire logic device_enable
);
	logic [7:0] oc_cnt_q;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// Counts cycles that port 0 is on while its flag is low; the filter must end this run.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			oc_cnt_q <= 8'h00;
		end else begin
			oc_cnt_q <= (port_power_pullup_en[0] && !port_power_enable_i[0]) ? oc_cnt_q + 8'h01 : 8'h00;
		end
	end
	a_strap_float: assert property ($rose(rst_n) |-> !rom_strap_data_oe && rom_strap_pulldown_en) else $error("strap pin");
	a_pull_drop: assert property ($rose(rst_n) |=> !rom_strap_pulldown_en) else $error("pull-down kept");
	a_clk_reset: assert property ($rose(rst_n) |-> rom_clock_oe && !rom_clock_o) else $error("rom clock");
	a_cs_suspend: assert property (suspend |-> rom_chip_sel_n) else $error("chip select low");
	a_port_drive: assert property ((port_power_enable_oe ^ port_power_pullup_en) == '1 && port_power_enable_o == '0)
		else $error("port pin drive");
	a_oc_limit: assert property (oc_cnt_q <= OC_FILTER + 2) else $error("port kept on");
	a_conn_gate: assert property (!upstream_power_sense |-> !upstream_pullup_en) else $error("pull-up on");
	a_dev_follow: assert property (device_enable == upstream_power_sense) else $error("device enable");
	a_power_loss: assert property (!upstream_power_sense |=> port_power_pullup_en == '0) else $error("ports on");
	a_ack_once: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
	cover property ($fell(port_power_pullup_en[0]));
	cover property (suspend && !rom_strap_data_oe);
	cover property ($fell(upstream_power_sense));
endmodule
bind pspc_pin_ctl pspc_pin_ctl_checker #(.NPORTS(NPORTS), .OC_FILTER(OC_FILTER)) i_chk (.sys_clk, .rst_n, .wb_ack_o,
	.suspend, .rom_strap_data_oe, .rom_strap_pulldown_en, .rom_clock_o, .rom_clock_oe, .rom_chip_sel_n,
	.port_power_enable_i, .port_power_enable_o, .port_power_enable_oe, .port_power_pullup_en,
	.upstream_power_sense, .upstream_pullup_en, .device_enable);

/* File: dv/testbench.sv */
// Self-checking testbench of the pin control block with a board model.
`timescale 1ns/1ps
module testbench;
	import pspc_pkg::*;
	localparam int OCF = 2;
	logic sys_clk = 1'b0, rst_n = 1'b0, wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, suspend = 1'b0;
	logic rom_shift_data = 1'b0, upstream_power_sense = 1'b1, card_detect_n = 1'b1, card_write_protect = 1'b0;
	logic strap = 1'b1, wb_ack_o, sd_i, sd_o, sd_oe, pd_en, ck_i, ck_o, ck_oe, cs_n, up_pu, dev_en, card_pwr, gpo;
	logic [15:0] wb_adr_i = 16'h0000;
	logic [31:0] wb_dat_i = 32'h00000000, wb_dat_o, rd;
	logic [3:0] wb_sel_i = 4'hF;
	logic [1:0] oc_fault = 2'b00, pp_i, pp_o, pp_oe, pp_pu;
	logic [2:0] swap;
	int failures = 0, compares = 0, n;
	// Rows: write flag, address, write byte, expected read byte.
	logic [32:0] rows [6] = '{{1'b0, 16'h2400, 8'h00, 8'h02}, {1'b0, 16'h2404, 8'h00, 8'h20},
		{1'b0, 16'h2408, 8'h00, 8'h00}, {1'b1, 16'h2404, 8'h7F, 8'h7F}, {1'b1, 16'h2408, 8'h0A, 8'h0A},
		{1'b1, 16'h2410, 8'hFF, 8'h00}};
	always #2.5 sys_clk = ~sys_clk;
	pspc_pin_ctl #(.NPORTS(2), .OC_FILTER(OCF)) i_dut (.sys_clk, .rst_n, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_sel_i,
		.wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .suspend, .rom_shift_data, .rom_strap_data_i(sd_i),
		.rom_strap_data_o(sd_o), .rom_strap_data_oe(sd_oe), .rom_strap_pulldown_en(pd_en), .rom_clock_i(ck_i),
		.rom_clock_o(ck_o), .rom_clock_oe(ck_oe), .rom_chip_sel_n(cs_n), .port_power_enable_i(pp_i),
		.port_power_enable_o(pp_o), .port_power_enable_oe(pp_oe), .port_power_pullup_en(pp_pu),
		.upstream_power_sense, .upstream_pullup_en(up_pu), .device_enable(dev_en), .diff_pair_swap(swap),
		.card_detect_n, .card_write_protect, .card_slot_power(card_pwr), .general_output_pin(gpo));
	pspc_board i_board (.strap, .oc_fault, .pp_o, .pp_oe, .pp_pu, .sd_o, .sd_oe, .ck_o, .ck_oe, .pp_pin(pp_i),
		.sd_pin(sd_i), .ck_pin(ck_i));
	task automatic results();
		if (failures == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One classic cycle; the request stands until ack is sampled, then drops for at least a cycle.
	task automatic bus(input logic [15:0] a, input logic [31:0] d, input logic we);
		int k;
		@(posedge sys_clk);
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_we_i <= we;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		k = 0;
		do begin
			@(posedge sys_clk);
			k++;
		end while (wb_ack_o !== 1'b1 && k < 20);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (wb_ack_o !== 1'b1) begin
			failures++;
			results();
		end
	endtask
	// Cycles between two changes of the ROM clock.
	task automatic half(output int h);
		logic p;
		int k;
		p = ck_o;
		for (k = 0; k < 30 && ck_o === p; k++) @(posedge sys_clk);
		p = ck_o;
		for (h = 0; h < 30 && ck_o === p; h++) @(posedge sys_clk);
		if (h >= 30) begin
			failures++;
			results();
		end
	endtask
	task automatic do_reset(input logic s, input int hold);
		strap <= s;
		rst_n <= 1'b0;
		repeat (hold) @(posedge sys_clk);
		chk({pd_en, sd_oe, ck_oe, ck_o, cs_n}, 5'b10101);
		rst_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		chk(pd_en, 1'b0);
	endtask
	// Register rows first, then port, card, connect, ROM speed and suspend cases.
	initial begin
		do_reset(1'b1, 16);
		foreach (rows[i]) begin
			if (rows[i][32]) bus(rows[i][31:16], {24'h000000, rows[i][15:8]}, 1'b1);
			bus(rows[i][31:16], 32'h00000000, 1'b0);
			chk(rd, {24'h000000, rows[i][7:0]});
		end
		chk({pp_pu, pp_oe, swap, gpo, card_pwr, up_pu}, {2'b11, 2'b00, 3'h7, 3'b111});
		oc_fault <= 2'b01;
		repeat (OCF + 6) @(posedge sys_clk);
		chk({pp_pu, pp_oe}, 4'b1001);
		bus(ADDR_STATUS, 32'h00000000, 1'b0);
		chk(rd[ST_OC_LSB +: 2], 2'b01);
		oc_fault <= 2'b00;
		bus(ADDR_STATUS, 32'h00000001, 1'b1);
		card_detect_n <= 1'b0;
		card_write_protect <= 1'b1;
		bus(ADDR_STATUS, 32'h00000000, 1'b0);
		chk({rd[ST_WP_BIT], rd[ST_CD_BIT], rd[ST_VBUS_BIT], rd[ST_OC_LSB +: 2]}, 5'b10100);
		upstream_power_sense <= 1'b0;
		repeat (2) @(posedge sys_clk);
		chk({up_pu, dev_en, pp_pu, card_pwr}, 5'b00000);
		upstream_power_sense <= 1'b1;
		bus(ADDR_ROM_CTL, 32'h00000009, 1'b1);
		half(n);
		chk(n, ROM_FAST_HALF_CYC);
		rom_shift_data <= 1'b1;
		@(posedge sys_clk);
		@(posedge sys_clk);
		chk({sd_oe, sd_o}, 2'b11);
		suspend <= 1'b1;
		repeat (2) @(posedge sys_clk);
		chk({sd_oe, cs_n}, 2'b01);
		suspend <= 1'b0;
		bus(ADDR_ROM_CTL, 32'h00000004, 1'b1);
		chk({ck_oe, ck_o, sd_oe, sd_o}, 4'b1010);
		bus(ADDR_ROM_CTL, 32'h00000034, 1'b1);
		chk({ck_oe, sd_oe}, 2'b00);
		do_reset(1'b0, 200);
		bus(ADDR_ROM_CTL, 32'h00000000, 1'b0);
		chk(rd, 32'h00000000);
		bus(ADDR_ROM_CTL, 32'h00000009, 1'b1);
		half(n);
		chk(n, ROM_SLOW_HALF_CYC);
		suspend <= 1'b1;
		repeat (2) @(posedge sys_clk);
		chk({sd_oe, sd_o}, 2'b10);
		results();
	end
endmodule

/* File: logic/pspc_pin_ctl.sv */
// Pin strap capture, serial ROM pin control, port power, connect gating and card pins.
//
// The register addresses and register access over Wishbone were left to the implementer.
`timescale 1ns/1ps
module pspc_pin_ctl #(
	parameter int NPORTS = 2,
	parameter int OC_FILTER = pspc_pkg::OC_FILTER_CYC
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [15:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic wb_ack_o,
	input wire logic suspend,
	input wire logic rom_shift_data,
	input wire logic rom_strap_data_i,
	output logic rom_strap_data_o,
	output logic rom_strap_data_oe,
	output logic rom_strap_pulldown_en,
	input wire logic rom_clock_i,
	output logic rom_clock_o,
	output logic rom_clock_oe,
	output logic rom_chip_sel_n,
	input wire logic [NPORTS-1:0] port_power_enable_i,
	output logic [NPORTS-1:0] port_power_enable_o,
	output logic [NPORTS-1:0] port_power_enable_oe,
	output logic [NPORTS-1:0] port_power_pullup_en,
	input wire logic upstream_power_sense,
	output logic upstream_pullup_en,
	output logic device_enable,
	output logic [NPORTS:0] diff_pair_swap,
	input wire logic card_detect_n,
	input wire logic card_write_protect,
	output logic card_slot_power,
	output logic general_output_pin
);
	import pspc_pkg::*;

	typedef struct packed {
		logic strap_done;
		logic strap;
		logic pd_en;
		logic rom_en;
		logic eep_mode;
		logic cs_act;
		logic eep_scl;
		logic eep_sda;
		logic rom_clk;
		logic [NPORTS-1:0] port_en;
		logic [NPORTS-1:0] oc_flag;
		logic [NPORTS-1:0][7:0] oc_cnt;
		logic [NPORTS:0] swap;
		logic conn_en;
		logic gpo;
		logic [3:0] card_cfg;
		logic ack;
		logic [31:0] rdata;
	} pspc_state_s;

	pspc_state_s s_q, s_d;
	logic rom_tick;
	logic rom_run;
	logic bus_req;
	logic bus_wr;
	logic [31:0] rd_mux;

	// Register image of one address, shared by the read path.
	function automatic logic [31:0] pspc_read(input logic [15:0] adr, input pspc_state_s s,
			input logic cd_n, input logic wp, input logic vbus, input logic sda);
		logic [31:0] r;
		r = 32'h0000_0000;
		case (adr)
			ADDR_ROM_CTL: begin
				r[ROM_EN_BIT] = s.rom_en;
				r[ROM_SPEED_BIT] = s.strap_done ? s.strap : ROM_CTL_RESET[ROM_SPEED_BIT];
				r[ROM_EEP_BIT] = s.eep_mode;
				r[ROM_CS_BIT] = s.cs_act;
				r[ROM_SCL_BIT] = s.eep_scl;
				r[ROM_SDA_BIT] = s.eep_sda;
			end
			ADDR_PORT_CTL: begin
				r[PORT_EN_LSB +: NPORTS] = s.port_en;
				r[SWAP_LSB +: NPORTS+1] = s.swap;
				r[CONN_EN_BIT] = s.conn_en;
				r[GPO_BIT] = s.gpo;
			end
			ADDR_CARD_PWR: begin
				r[3:0] = s.card_cfg;
			end
			ADDR_STATUS: begin
				r[ST_OC_LSB +: NPORTS] = s.oc_flag;
				r[ST_CD_BIT] = cd_n;
				r[ST_WP_BIT] = wp;
				r[ST_VBUS_BIT] = vbus;
				r[ST_SDA_BIT] = sda;
			end
			default: begin
				r = 32'h0000_0000;
			end
		endcase
		return r;
	endfunction

	// Bus request is taken once per access; ack drops the cycle after it rises.
	assign bus_req = wb_cyc_i && wb_stb_i && !s_q.ack;
	assign bus_wr = bus_req && wb_we_i && wb_sel_i[0];
	assign rd_mux = pspc_read(wb_adr_i, s_q, card_detect_n, card_write_protect,
			upstream_power_sense, rom_strap_data_i);

	// The ROM clock only runs during a selected access in serial ROM mode.
	assign rom_run = s_q.strap_done && s_q.rom_en && s_q.cs_act && !s_q.eep_mode && !suspend && device_enable;

	// Half period follows the latched strap, so the speed is fixed until the next reset.
	pspc_tick_div #(
		.WIDTH(4)
	) u_rom_div (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.run(rom_run),
		.half_cyc(s_q.strap ? 4'(ROM_FAST_HALF_CYC) : 4'(ROM_SLOW_HALF_CYC)),
		.tick(rom_tick)
	);

	// Next state: strap capture, bus access, over-current tracking and ROM clock.
	always_comb begin
		s_d = s_q;
		s_d.ack = bus_req;
		if (bus_req) begin
			s_d.rdata = rd_mux;
		end
		// The first edge after release takes the strap; the pull-down then goes away.
		if (!s_q.strap_done) begin
			s_d.strap = rom_strap_data_i;
			s_d.strap_done = 1'b1;
			s_d.pd_en = 1'b0;
		end
		if (bus_wr) begin
			case (wb_adr_i)
				ADDR_ROM_CTL: begin
					s_d.rom_en = wb_dat_i[ROM_EN_BIT];
					s_d.eep_mode = wb_dat_i[ROM_EEP_BIT];
					s_d.cs_act = wb_dat_i[ROM_CS_BIT];
					s_d.eep_scl = wb_dat_i[ROM_SCL_BIT];
					s_d.eep_sda = wb_dat_i[ROM_SDA_BIT];
				end
				ADDR_PORT_CTL: begin
					s_d.port_en = wb_dat_i[PORT_EN_LSB +: NPORTS];
					s_d.swap = wb_dat_i[SWAP_LSB +: NPORTS+1];
					s_d.conn_en = wb_dat_i[CONN_EN_BIT];
					s_d.gpo = wb_dat_i[GPO_BIT];
				end
				ADDR_CARD_PWR: begin
					s_d.card_cfg = wb_dat_i[3:0];
				end
				ADDR_STATUS: begin
					s_d.oc_flag = s_q.oc_flag & ~wb_dat_i[ST_OC_LSB +: NPORTS];
				end
				default: begin
				end
			endcase
		end
		// A low on an enabled port pin that outlasts the filter turns that port off.
		// The filter also hides the slow rise of the pull-up right after enabling.
		for (int p = 0; p < NPORTS; p++) begin
			if (!s_q.port_en[p] || port_power_enable_i[p]) begin
				s_d.oc_cnt[p] = 8'h00;
			end else if (s_q.oc_cnt[p] + 8'h01 >= 8'(OC_FILTER)) begin
				s_d.oc_cnt[p] = 8'h00;
				s_d.port_en[p] = 1'b0;
				s_d.oc_flag[p] = 1'b1;
			end else begin
				s_d.oc_cnt[p] = s_q.oc_cnt[p] + 8'h01;
			end
		end
		// Losing upstream power shuts every port, as the whole device is disabled.
		if (!upstream_power_sense) begin
			s_d.port_en = '0;
		end
		// ROM clock toggles on each divider tick and parks low when idle.
		if (!rom_run) begin
			s_d.rom_clk = 1'b0;
		end else if (rom_tick) begin
			s_d.rom_clk = !s_q.rom_clk;
		end
	end

	// Register stage; reset puts every pin into its documented reset state.
	// The reference clock is taken as already multiplied up to sys_clk before it gets here.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
			s_q.pd_en <= 1'b1;
			s_q.conn_en <= PORT_CTL_RESET[CONN_EN_BIT];
			s_q.rom_en <= ROM_CTL_RESET[ROM_EN_BIT];
		end else begin
			s_q <= s_d;
		end
	end

	// Bus outputs.
	assign wb_ack_o = s_q.ack;
	assign wb_dat_o = s_q.rdata;

	// Shared strap, ROM data and EEPROM data pin.
	always_comb begin
		rom_strap_pulldown_en = s_q.pd_en;
		rom_strap_data_o = 1'b0;
		rom_strap_data_oe = 1'b0;
		if (!s_q.strap_done) begin
			rom_strap_data_oe = 1'b0;
		end else if (suspend) begin
			rom_strap_data_oe = !s_q.strap;
		end else if (s_q.eep_mode) begin
			rom_strap_data_oe = !s_q.eep_sda;
		end else begin
			rom_strap_data_oe = 1'b1;
			rom_strap_data_o = s_q.rom_en && rom_shift_data;
		end
	end

	// ROM clock pin; low while reset is held or before the strap is taken.
	always_comb begin
		rom_clock_o = 1'b0;
		rom_clock_oe = 1'b1;
		if (s_q.strap_done && s_q.eep_mode && !suspend) begin
			rom_clock_oe = !s_q.eep_scl;
		end else begin
			rom_clock_o = s_q.rom_clk;
		end
	end

	// Chip select stays high in reset, suspend and whenever not requested.
	assign rom_chip_sel_n = !(s_q.strap_done && s_q.rom_en && s_q.cs_act && !s_q.eep_mode && !suspend);

	// Port power pins: driven low when off, released with pull-up when on.
	always_comb begin
		for (int p = 0; p < NPORTS; p++) begin
			port_power_enable_o[p] = 1'b0;
			port_power_enable_oe[p] = !s_q.port_en[p];
			port_power_pullup_en[p] = s_q.port_en[p];
		end
	end

	// Connect pull-up drops the cycle power is lost, well inside the allowed 10 s.
	assign device_enable = upstream_power_sense;
	assign upstream_pullup_en = s_q.strap_done && s_q.conn_en && upstream_power_sense;

	// Loose outputs from registers; card slot power is also gated by device_enable.
	assign diff_pair_swap = s_q.swap;
	assign card_slot_power = |s_q.card_cfg && device_enable;
	assign general_output_pin = s_q.gpo;
endmodule

/* File: logic/pspc_pkg.sv */
// Package with offsets, field positions, reset values and timing counts of the pin control block.
package pspc_pkg;
	// System clock rate, used to derive the ROM clock half periods.
	localparam int SYS_CLK_MHZ = 200;
	// Serial ROM clock rates chosen by the speed strap.
	localparam int ROM_SLOW_MHZ = 30;
	localparam int ROM_FAST_MHZ = 60;
	// Half periods round up so the ROM clock never exceeds its rated speed.
	localparam int ROM_SLOW_HALF_CYC = (SYS_CLK_MHZ + 2 * ROM_SLOW_MHZ - 1) / (2 * ROM_SLOW_MHZ);
	localparam int ROM_FAST_HALF_CYC = (SYS_CLK_MHZ + 2 * ROM_FAST_MHZ - 1) / (2 * ROM_FAST_MHZ);
	// Over-current filter length in cycles.
	localparam int OC_FILTER_CYC = 16;
	// Register byte addresses on the bus.
	localparam logic [15:0] ADDR_ROM_CTL = 16'h2400;
	localparam logic [15:0] ADDR_PORT_CTL = 16'h2404;
	localparam logic [15:0] ADDR_CARD_PWR = 16'h2408;
	localparam logic [15:0] ADDR_STATUS = 16'h240C;
	// Field positions of rom_control_reg.
	localparam int ROM_EN_BIT = 0;
	localparam int ROM_SPEED_BIT = 1;
	localparam int ROM_EEP_BIT = 2;
	localparam int ROM_CS_BIT = 3;
	localparam int ROM_SCL_BIT = 4;
	localparam int ROM_SDA_BIT = 5;
	localparam logic [7:0] ROM_CTL_RESET = 8'h02;
	// Field positions of the port control register.
	localparam int PORT_EN_LSB = 0;
	localparam int SWAP_LSB = 2;
	localparam int CONN_EN_BIT = 5;
	localparam int GPO_BIT = 6;
	localparam logic [7:0] PORT_CTL_RESET = 8'h20;
	// Field positions of the status register.
	localparam int ST_OC_LSB = 0;
	localparam int ST_CD_BIT = 2;
	localparam int ST_WP_BIT = 3;
	localparam int ST_VBUS_BIT = 4;
	localparam int ST_SDA_BIT = 5;
endpackage

/* File: logic/pspc_tick_div.sv */
// Divider that turns the system clock into a one-cycle enable every half_cyc cycles.
`timescale 1ns/1ps
module pspc_tick_div #(
	parameter int WIDTH = 4
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic run,
	input wire logic [WIDTH-1:0] half_cyc,
	output logic tick
);
	typedef struct packed {
		logic [WIDTH-1:0] cnt;
		logic tick;
	} pspc_div_s;

	pspc_div_s s_q, s_d;

	// Count up while running; restart from zero whenever stopped.
	always_comb begin
		s_d = s_q;
		s_d.tick = 1'b0;
		if (!run) begin
			s_d.cnt = '0;
		end else if (s_q.cnt + WIDTH'(1) >= half_cyc) begin
			s_d.cnt = '0;
			s_d.tick = 1'b1;
		end else begin
			s_d.cnt = s_q.cnt + WIDTH'(1);
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign tick = s_q.tick;
endmodule
